// file: verilog/itex_execute_unit.sv
// execute stage for truncation, standby, shadow write, byte swap and exclusive-or
`timescale 1ns/1ps
`include "itex_params.svh"
module itex_execute_unit
	import itex_pkg::*;
#(
	parameter int SET_W = 4,
	parameter bit WAKE_ON_MASKED = 1'b1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// instruction in
	input wire logic in_valid,
	input wire logic [31:0] in_instr,
	input wire logic [31:0] in_pc,
	input wire logic [31:0] rs_value,
	input wire logic [31:0] rt_value,
	input wire logic [63:0] fpr_src,
	// configuration
	input wire logic release2,
	input wire logic syscop_usable,
	input wire logic fpu_usable,
	input wire logic float_control_status_reg_invalid_enable,
	input wire logic float_control_status_reg_inexact_enable,
	input wire logic [SET_W-1:0] prev_shadow_set_field,
	// wake events
	input wire logic irq_enabled_req,
	input wire logic irq_masked_req,
	input wire logic nmi_req,
	input wire logic reset_req,
	// general register write
	output logic gpr_we,
	output logic [4:0] gpr_idx,
	output logic [31:0] gpr_data,
	// float register write
	output logic fpr_we,
	output logic [4:0] fpr_idx,
	output logic [31:0] fpr_data,
	output logic float_control_status_reg_invalid_set,
	output logic float_control_status_reg_inexact_set,
	// shadow register write
	output logic shadow_we,
	output logic [SET_W-1:0] shadow_set,
	output logic [4:0] shadow_idx,
	output logic [31:0] shadow_data,
	// exceptions and pipeline
	output logic exc_valid,
	output itex_exc_type exc_code,
	output logic [31:0] exc_return_addr,
	output logic pass_on,
	output itex_class_type pass_class,
	output logic standby_stall,
	output logic restart
);

	// ----------------------------------------
	// fields
	// ----------------------------------------
	wire [5:0] opc = in_instr[31:26];
	wire [4:0] f_rs = in_instr[25:21];
	wire [4:0] f_rt = in_instr[20:16];
	wire [4:0] f_rd = in_instr[15:11];
	wire [4:0] f_sa = in_instr[10:6];
	wire [5:0] fn = in_instr[5:0];

	// ----------------------------------------
	// decode, primary opcode first
	// ----------------------------------------
	wire op_reg = (opc == `ITEX_OP_REGCLASS);
	wire op_reg_imm = (opc == `ITEX_OP_REG_IMM);
	wire op_sys = (opc == `ITEX_OP_SYSCOP);
	wire op_flt = (opc == `ITEX_OP_FLOAT);
	wire op_sp3 = (opc == `ITEX_OP_THIRD_CLASS);
	wire op_xor_imm = (opc == `ITEX_OP_XOR_IMM);
	wire op_rsvd = (opc == `ITEX_OP_RESERVED);
	wire is_xor = op_reg && (f_sa == 5'h00) && (fn == `ITEX_FN_XOR);
	wire fn_rsvd = (fn == 6'h0e) || (fn == 6'h28) || (fn == 6'h29) || (fn == 6'h35) ||
		(fn == 6'h37) || (fn == 6'h39) || (fn == 6'h3d);
	wire reg_rsvd = op_reg && fn_rsvd;
	wire is_swap = op_sp3 && (f_rs == 5'h00) && (f_sa == `ITEX_SA_SWAP) &&
		(fn == `ITEX_FN_SHUFFLE);
	wire is_standby = op_sys && in_instr[`ITEX_SYS_OP_BIT] && (fn == `ITEX_FN_STANDBY);
	wire is_shadow = op_sys && (f_rs == `ITEX_RS_SHADOW_WR) &&
		(in_instr[10:0] == 11'h000);
	wire is_trunc = op_flt && (f_rt == 5'h00) && (fn == `ITEX_FN_TRUNC_WORD);
	wire fmt_ok = (f_rs == `ITEX_FMT_SINGLE) || (f_rs == `ITEX_FMT_DOUBLE);
	wire [31:0] swap_val = {rt_value[23:16], rt_value[31:24], rt_value[7:0], rt_value[15:8]};
	wire [31:0] immediate_exclusive_or_val = rs_value ^ {16'h0, in_instr[15:0]};

	// ----------------------------------------
	// truncation unit
	// ----------------------------------------
	itex_trunc_if tif ();
	assign tif.src = fpr_src;
	assign tif.is_double = (f_rs == `ITEX_FMT_DOUBLE);
	itex_trunc_unit u_trunc (
		.tif(tif.unit)
	);

	// ----------------------------------------
	// standby state
	// ----------------------------------------
	itex_state_type state_q;
	itex_state_type state_d;
	logic [31:0] next_pc_q;
	wire running = (state_q == ITEX_RUN);
	wire take = in_valid && running;
	wire masked_wake = WAKE_ON_MASKED && irq_masked_req;
	wire wake = reset_req || nmi_req || irq_enabled_req || masked_wake;
	wire enter_standby = take && is_standby && syscop_usable;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ITEX_RUN: begin
				if (enter_standby) begin
					state_d = ITEX_STANDBY;
				end
			end
			ITEX_STANDBY: begin
				if (wake) begin
					state_d = ITEX_RUN;
				end
			end
		endcase
	end

	// ----------------------------------------
	// next values
	// ----------------------------------------
	logic gpr_we_d;
	logic [4:0] gpr_idx_d;
	logic [31:0] gpr_data_d;
	logic fpr_we_d;
	logic [31:0] fpr_data_d;
	logic inv_set_d;
	logic inx_set_d;
	logic shadow_we_d;
	logic exc_valid_d;
	itex_exc_type exc_code_d;
	logic [31:0] exc_addr_d;
	logic pass_d;
	itex_class_type cls_d;

	always_comb begin
		gpr_we_d = 1'b0;
		gpr_idx_d = f_rd;
		gpr_data_d = 32'h0;
		fpr_we_d = 1'b0;
		fpr_data_d = tif.result;
		inv_set_d = 1'b0;
		inx_set_d = 1'b0;
		shadow_we_d = 1'b0;
		exc_valid_d = 1'b0;
		exc_code_d = ITEX_EXC_NONE;
		exc_addr_d = in_pc;
		pass_d = 1'b0;
		cls_d = ITEX_CLS_NONE;
		if (!running && wake) begin
			exc_addr_d = next_pc_q;
			exc_valid_d = !(masked_wake && !reset_req && !nmi_req && !irq_enabled_req);
			if (reset_req) begin
				exc_code_d = ITEX_EXC_NMI;
			end else if (nmi_req) begin
				exc_code_d = ITEX_EXC_NMI;
			end else if (irq_enabled_req) begin
				exc_code_d = ITEX_EXC_INTERRUPT;
			end
		end else if (take) begin
			if (op_rsvd || reg_rsvd || (op_sp3 && !release2) ||
				(is_shadow && !release2)) begin
				exc_valid_d = 1'b1;
				exc_code_d = ITEX_EXC_RESERVED;
			end else if (is_xor) begin
				gpr_we_d = 1'b1;
				gpr_data_d = rs_value ^ rt_value;
			end else if (op_xor_imm) begin
				gpr_we_d = 1'b1;
				gpr_idx_d = f_rt;
				gpr_data_d = immediate_exclusive_or_val;
			end else if (is_swap) begin
				gpr_we_d = 1'b1;
				gpr_data_d = swap_val;
			end else if (op_sys && !syscop_usable) begin
				exc_valid_d = 1'b1;
				exc_code_d = ITEX_EXC_UNUSABLE;
			end else if (is_shadow) begin
				shadow_we_d = 1'b1;
			end else if (is_standby) begin
				exc_valid_d = 1'b0;
			end else if (is_trunc && !fpu_usable) begin
				exc_valid_d = 1'b1;
				exc_code_d = ITEX_EXC_UNUSABLE;
			end else if (is_trunc && !fmt_ok) begin
				exc_valid_d = 1'b1;
				exc_code_d = ITEX_EXC_FP_UNIMPL;
			end else if (is_trunc && tif.invalid) begin
				inv_set_d = 1'b1;
				exc_valid_d = float_control_status_reg_invalid_enable;
				exc_code_d = float_control_status_reg_invalid_enable ? ITEX_EXC_FP_INVALID : ITEX_EXC_NONE;
				fpr_we_d = !float_control_status_reg_invalid_enable;
				fpr_data_d = `ITEX_TRUNC_DEFAULT;
			end else if (is_trunc) begin
				inx_set_d = tif.inexact;
				exc_valid_d = tif.inexact && float_control_status_reg_inexact_enable;
				exc_code_d = exc_valid_d ? ITEX_EXC_FP_INEXACT : ITEX_EXC_NONE;
				fpr_we_d = !exc_valid_d;
			end else begin
				pass_d = 1'b1;
				cls_d = op_reg ? ITEX_CLS_REGCLASS : op_reg_imm ? ITEX_CLS_REG_IMM :
					op_sys ? ITEX_CLS_SYSCOP : op_flt ? ITEX_CLS_FLOAT :
					op_sp3 ? ITEX_CLS_THIRD : ITEX_CLS_OTHER;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ITEX_RUN;
			next_pc_q <= 32'h0;
			gpr_we <= 1'b0;
			gpr_idx <= 5'h00;
			gpr_data <= 32'h0;
			fpr_we <= 1'b0;
			fpr_idx <= 5'h00;
			fpr_data <= 32'h0;
			float_control_status_reg_invalid_set <= 1'b0;
			float_control_status_reg_inexact_set <= 1'b0;
			shadow_we <= 1'b0;
			shadow_set <= '0;
			shadow_idx <= 5'h00;
			shadow_data <= 32'h0;
			exc_valid <= 1'b0;
			exc_code <= ITEX_EXC_NONE;
			exc_return_addr <= 32'h0;
			pass_on <= 1'b0;
			pass_class <= ITEX_CLS_NONE;
			restart <= 1'b0;
		end else begin
			state_q <= state_d;
			if (enter_standby) begin
				next_pc_q <= in_pc + `ITEX_PC_STEP;
			end
			gpr_we <= gpr_we_d;
			gpr_idx <= gpr_idx_d;
			gpr_data <= gpr_data_d;
			fpr_we <= fpr_we_d;
			fpr_idx <= in_instr[10:6];
			fpr_data <= fpr_data_d;
			float_control_status_reg_invalid_set <= inv_set_d;
			float_control_status_reg_inexact_set <= inx_set_d;
			shadow_we <= shadow_we_d;
			shadow_set <= prev_shadow_set_field;
			shadow_idx <= f_rd;
			shadow_data <= rt_value;
			exc_valid <= exc_valid_d;
			exc_code <= exc_code_d;
			exc_return_addr <= exc_addr_d;
			pass_on <= pass_d;
			pass_class <= cls_d;
			restart <= !running && wake;
		end
	end

	assign standby_stall = (state_q == ITEX_STANDBY);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	property p_xor;
		take && is_xor && !reg_rsvd |=> gpr_we && !exc_valid &&
			gpr_data == ($past(rs_value) ^ $past(rt_value));
	endproperty
	a_xor: assert property (p_xor) else $error("register xor result wrong");
	property p_xor_imm;
		take && op_xor_imm |=> gpr_we && gpr_idx == $past(f_rt) &&
			gpr_data == ($past(rs_value) ^ {16'h0, $past(in_instr[15:0])});
	endproperty
	a_xor_imm: assert property (p_xor_imm) else $error("immediate xor result wrong");
	property p_swap;
		take && is_swap && release2 |=> gpr_we && !exc_valid &&
			gpr_data == {$past(rt_value[23:16]), $past(rt_value[31:24]),
			$past(rt_value[7:0]), $past(rt_value[15:8])};
	endproperty
	a_swap: assert property (p_swap) else $error("byte swap order wrong");
	property p_shadow;
		take && is_shadow && release2 && syscop_usable |=> shadow_we &&
			shadow_data == $past(rt_value) && shadow_set == $past(prev_shadow_set_field);
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow write wrong");
	property p_old_release;
		take && (is_swap || is_shadow) && !release2 |=> exc_valid &&
			exc_code == ITEX_EXC_RESERVED && !gpr_we && !shadow_we;
	endproperty
	a_old_release: assert property (p_old_release) else $error("old release not reserved");
	property p_trunc_trap;
		take && is_trunc && fmt_ok && fpu_usable && tif.invalid && float_control_status_reg_invalid_enable
			|=> !fpr_we && float_control_status_reg_invalid_set && exc_code == ITEX_EXC_FP_INVALID;
	endproperty
	a_trunc_trap: assert property (p_trunc_trap) else $error("invalid trap wrong");
	property p_trunc_default;
		take && is_trunc && fmt_ok && fpu_usable && tif.invalid && !float_control_status_reg_invalid_enable
			|=> fpr_we && fpr_data == `ITEX_TRUNC_DEFAULT && !exc_valid;
	endproperty
	a_trunc_default: assert property (p_trunc_default) else $error("default result wrong");
	property p_standby;
		enter_standby ##1 !wake |=> standby_stall [*1] ##0 !gpr_we;
	endproperty
	a_standby: assert property (p_standby) else $error("standby did not stall");
	property p_nmi_wake;
		standby_stall && !reset_req && nmi_req |=> !standby_stall && restart && exc_valid &&
			exc_code == ITEX_EXC_NMI;
	endproperty
	a_nmi_wake: assert property (p_nmi_wake) else $error("nmi did not restart");
	property p_irq_addr;
		enter_standby ##1 (standby_stall && irq_enabled_req && !nmi_req && !reset_req)
			|=> exc_code == ITEX_EXC_INTERRUPT && exc_return_addr == $past(in_pc, 2) + 32'h4;
	endproperty
	a_irq_addr: assert property (p_irq_addr) else $error("interrupt return address wrong");
	property p_unusable;
		take && is_standby && !syscop_usable |=> !standby_stall && exc_valid &&
			exc_code == ITEX_EXC_UNUSABLE;
	endproperty
	a_unusable: assert property (p_unusable) else $error("standby not refused");

endmodule

// file: verilog/itex_params.svh
// constants for the instruction tail execute unit
`ifndef ITEX_PARAMS_SVH
`define ITEX_PARAMS_SVH

// ----------------------------------------
// primary opcodes
// ----------------------------------------
`define ITEX_OP_REGCLASS 6'h00
`define ITEX_OP_REG_IMM 6'h01
`define ITEX_OP_XOR_IMM 6'h0e
`define ITEX_OP_SYSCOP 6'h10
`define ITEX_OP_FLOAT 6'h11
`define ITEX_OP_THIRD_CLASS 6'h1f
`define ITEX_OP_RESERVED 6'h3b

// ----------------------------------------
// function and field codes
// ----------------------------------------
`define ITEX_FN_STANDBY 6'h20
`define ITEX_FN_XOR 6'h26
`define ITEX_FN_SHUFFLE 6'h20
`define ITEX_FN_TRUNC_WORD 6'h0d
`define ITEX_SA_SWAP 5'h02
`define ITEX_RS_SHADOW_WR 5'h0e
`define ITEX_FMT_SINGLE 5'h10
`define ITEX_FMT_DOUBLE 5'h11

// ----------------------------------------
// field positions
// ----------------------------------------
`define ITEX_SYS_OP_BIT 25

// ----------------------------------------
// values
// ----------------------------------------
`define ITEX_TRUNC_DEFAULT 32'h7fffffff
`define ITEX_TRUNC_MIN 32'h80000000
`define ITEX_DBL_BIAS 11'h3ff
`define ITEX_SGL_REBIAS 11'h380
`define ITEX_EXP_ALL_ONES 11'h7ff
`define ITEX_WORD_MAX_EXP 11'h01f
`define ITEX_MANT_TOP 6'h34
`define ITEX_PC_STEP 32'h00000004

`endif

// file: verilog/itex_pkg.sv
// types for the instruction tail execute unit
package itex_pkg;

	typedef enum logic {
		ITEX_RUN = 1'b0,
		ITEX_STANDBY = 1'b1
	} itex_state_type;

	typedef enum logic [2:0] {
		ITEX_EXC_NONE = 3'h0,
		ITEX_EXC_RESERVED = 3'h1,
		ITEX_EXC_UNUSABLE = 3'h2,
		ITEX_EXC_FP_INVALID = 3'h3,
		ITEX_EXC_FP_INEXACT = 3'h4,
		ITEX_EXC_FP_UNIMPL = 3'h5,
		ITEX_EXC_INTERRUPT = 3'h6,
		ITEX_EXC_NMI = 3'h7
	} itex_exc_type;

	typedef enum logic [2:0] {
		ITEX_CLS_NONE = 3'h0,
		ITEX_CLS_REGCLASS = 3'h1,
		ITEX_CLS_REG_IMM = 3'h2,
		ITEX_CLS_SYSCOP = 3'h3,
		ITEX_CLS_FLOAT = 3'h4,
		ITEX_CLS_THIRD = 3'h5,
		ITEX_CLS_OTHER = 3'h6
	} itex_class_type;

endpackage

// file: verilog/itex_trunc_if.sv
// carrier between the execute unit and the truncation unit
`timescale 1ns/1ps
interface itex_trunc_if;
	logic [63:0] src;
	logic is_double;
	logic [31:0] result;
	logic invalid;
	logic inexact;

	modport unit (
		input src,
		input is_double,
		output result,
		output invalid,
		output inexact
	);

	modport user (
		output src,
		output is_double,
		input result,
		input invalid,
		input inexact
	);
endinterface

// file: verilog/itex_trunc_unit.sv
// float to word truncation toward zero
`timescale 1ns/1ps
`include "itex_params.svh"
module itex_trunc_unit
	import itex_pkg::*;
(
	// operand and result
	itex_trunc_if.unit tif
);

	// ----------------------------------------
	// unpack to double layout
	// ----------------------------------------
	wire [7:0] s_exp = tif.src[30:23];
	wire sign = tif.is_double ? tif.src[63] : tif.src[31];
	wire [10:0] s_exp_w = (s_exp == 8'h00) ? 11'h000 :
		(s_exp == 8'hff) ? `ITEX_EXP_ALL_ONES : ({3'h0, s_exp} + `ITEX_SGL_REBIAS);
	wire [10:0] exp11 = tif.is_double ? tif.src[62:52] : s_exp_w;
	wire [51:0] frac = tif.is_double ? tif.src[51:0] : {tif.src[22:0], 29'h0};

	// ----------------------------------------
	// magnitude and range
	// ----------------------------------------
	wire register_class_opcode = (exp11 == `ITEX_EXP_ALL_ONES);
	wire zero_mag = (exp11 == 11'h000) && (frac == 52'h0);
	wire below_one = (exp11 < `ITEX_DBL_BIAS);
	wire [10:0] ue = exp11 - `ITEX_DBL_BIAS;
	wire min_word = sign && (ue == `ITEX_WORD_MAX_EXP) && (frac[51:21] == 31'h0);
	wire too_big = !below_one && !register_class_opcode && (ue >= `ITEX_WORD_MAX_EXP) && !min_word;
	wire [5:0] sh = `ITEX_MANT_TOP - ue[5:0];
	wire [52:0] full = {1'b1, frac};
	wire [52:0] mag = full >> sh;
	wire lost = |(full & ~({53{1'b1}} << sh));
	wire [31:0] mag_w = {1'b0, mag[30:0]};
	wire in_range = !below_one && !too_big && !register_class_opcode && !min_word;

	// ----------------------------------------
	// result and flags
	// ----------------------------------------
	assign tif.result = below_one ? 32'h0 : min_word ? `ITEX_TRUNC_MIN :
		(sign ? (32'h0 - mag_w) : mag_w);
	assign tif.invalid = register_class_opcode || too_big;
	assign tif.inexact = below_one ? !zero_mag : ((in_range || min_word) && lost);

endmodule

// file: testbench/itex_regfile_model.sv
// general register file model on the far side of the execute unit
`timescale 1ns/1ps
module itex_regfile_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// operand read
	input wire logic [31:0] in_instr,
	output logic [31:0] rs_value,
	output logic [31:0] rt_value,
	// write back
	input wire logic gpr_we,
	input wire logic [4:0] gpr_idx,
	input wire logic [31:0] gpr_data
);
	logic [31:0] regs_q [32];

	// ----------------------------------------
	// register file, register 0 reads zero
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 1; i < 32; i++) begin
				regs_q[i] <= {3'h1, 5'(i), 3'h2, 5'(i), 3'h3, 5'(i), 3'h4, 5'(i)};
			end
			regs_q[0] <= 32'h0;
		end else if (gpr_we && gpr_idx != 5'h0) begin
			regs_q[gpr_idx] <= gpr_data;
		end
	end

	assign rs_value = regs_q[in_instr[25:21]];
	assign rt_value = regs_q[in_instr[20:16]];
endmodule

// file: testbench/itex_execute_unit_tb.sv
// self-checking bench for the instruction tail execute unit
`timescale 1ns/1ps
module itex_execute_unit_tb;
	import itex_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic ref_clk, nrst, in_valid, release2, syscop_usable, fpu_usable;
	logic float_control_status_reg_invalid_enable, float_control_status_reg_inexact_enable;
	logic irq_enabled_req, irq_masked_req, nmi_req, reset_req;
	logic [31:0] in_instr, in_pc, rs_value, rt_value, gpr_data, fpr_data, shadow_data;
	logic [31:0] exc_return_addr, pc_save, v;
	logic [63:0] fpr_src;
	logic [3:0] prev_shadow_set_field, shadow_set;
	logic [4:0] gpr_idx, fpr_idx, shadow_idx;
	logic gpr_we, fpr_we, float_control_status_reg_invalid_set, float_control_status_reg_inexact_set, shadow_we;
	logic exc_valid, pass_on, standby_stall, restart;
	itex_exc_type exc_code;
	itex_class_type pass_class;
	int err_total, checked;
	logic [34:0] pass_tab [6];

	itex_execute_unit dut (.*);
	itex_regfile_model far_regs (.*);

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] pat(input logic [4:0] i);
		return (i == 5'h0) ? 32'h0 : {3'h1, i, 3'h2, i, 3'h3, i, 3'h4, i};
	endfunction

	function automatic logic [31:0] sb(input logic [18:0] code);
		return {6'h10, 1'b1, code, 6'h20};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic issue(input logic [31:0] ins);
		@(negedge ref_clk);
		in_instr = ins;
		in_pc = in_pc + 32'h4;
		in_valid = 1'b1;
		@(negedge ref_clk);
		in_valid = 1'b0;
	endtask

	task automatic exc(input logic [2:0] code);
		chk({28'h0, exc_valid, exc_code}, {28'h0, code != 3'h0, code});
	endtask

	task automatic general_register(input logic [4:0] idx, input logic [31:0] d);
		chk({26'h0, gpr_we, gpr_idx}, {26'h0, 1'b1, idx});
		chk(gpr_data, d);
		exc(3'h0);
	endtask

	task automatic trn(input logic [4:0] fmt, input logic [63:0] src, input logic [31:0] d,
			input logic [1:0] flags, input logic [2:0] code);
		fpr_src = src;
		issue({6'h11, fmt, 5'h0, 5'h2, 5'hc, 6'h0d});
		chk({30'h0, float_control_status_reg_invalid_set, float_control_status_reg_inexact_set}, {30'h0, flags});
		exc(code);
		chk({31'h0, fpr_we}, {31'h0, code == 3'h0});
		if (code == 3'h0) begin
			chk({27'h0, fpr_idx}, 32'hc);
			chk(fpr_data, d);
		end
	endtask

	task automatic wake(input logic [3:0] w, input logic [2:0] code);
		{reset_req, nmi_req, irq_enabled_req, irq_masked_req} = w;
		@(negedge ref_clk);
		{reset_req, nmi_req, irq_enabled_req, irq_masked_req} = 4'h0;
		chk({30'h0, restart, standby_stall}, 32'h2);
		exc(code);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		summarize();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		pass_tab[0] = {6'h01, 5'h1, 5'h0c, 16'h0, 3'h2};
		pass_tab[1] = {6'h00, 5'h1, 5'h2, 5'h3, 5'h0, 6'h20, 3'h1};
		pass_tab[2] = {6'h08, 5'h1, 5'h2, 16'h7, 3'h6};
		pass_tab[3] = {6'h10, 5'h0, 5'h2, 5'h3, 11'h0, 3'h3};
		pass_tab[4] = {6'h11, 5'h10, 5'h0, 5'h1, 5'h2, 6'h0, 3'h4};
		pass_tab[5] = {6'h1f, 5'h1, 5'h2, 5'h3, 5'h0, 6'h0, 3'h5};
		{nrst, in_valid, release2, syscop_usable, fpu_usable} = 5'b00111;
		{float_control_status_reg_invalid_enable, float_control_status_reg_inexact_enable} = 2'b00;
		{reset_req, nmi_req, irq_enabled_req, irq_masked_req} = 4'h0;
		in_instr = 32'h0;
		in_pc = 32'h0000_1000;
		fpr_src = 64'h0;
		prev_shadow_set_field = 4'h9;
		repeat (3) @(negedge ref_clk);
		nrst = 1'b1;
		chk({29'h0, standby_stall, gpr_we, exc_valid}, 32'h0);
		issue({6'h00, 5'h1, 5'h2, 5'h3, 5'h0, 6'h26});
		general_register(5'h3, pat(5'h1) ^ pat(5'h2));
		issue({6'h00, 5'h3, 5'h2, 5'h4, 5'h0, 6'h26});
		general_register(5'h4, pat(5'h1));
		issue({6'h0e, 5'h5, 5'h6, 16'h8001});
		general_register(5'h6, pat(5'h5) ^ 32'h0000_8001);
		issue({6'h1f, 5'h0, 5'h7, 5'h8, 5'h02, 6'h20});
		v = pat(5'h7);
		general_register(5'h8, {v[23:16], v[31:24], v[7:0], v[15:8]});
		issue({6'h10, 5'h0e, 5'h9, 5'ha, 11'h0});
		chk({21'h0, shadow_we, shadow_set, shadow_idx, gpr_we},
			{21'h0, 1'b1, 4'h9, 5'ha, 1'b0});
		chk(shadow_data, pat(5'h9));
		release2 = 1'b0;
		issue({6'h1f, 5'h0, 5'h7, 5'h8, 5'h02, 6'h20});
		exc(3'h1);
		issue({6'h10, 5'h0e, 5'h9, 5'ha, 11'h0});
		chk({30'h0, shadow_we, gpr_we}, 32'h0);
		exc(3'h1);
		release2 = 1'b1;
		issue({6'h3b, 26'h0});
		exc(3'h1);
		issue({6'h00, 5'h1, 5'h2, 5'h3, 5'h0, 6'h0e});
		exc(3'h1);
		foreach (pass_tab[i]) begin
			issue(pass_tab[i][34:3]);
			chk({28'h0, pass_on, pass_class}, {28'h0, 1'b1, pass_tab[i][2:0]});
		end
		trn(5'h10, 64'h4070_0000, 32'h3, 2'b01, 3'h0);
		trn(5'h10, 64'hc020_0000, 32'hffff_fffe, 2'b01, 3'h0);
		trn(5'h11, 64'h4059_0000_0000_0000, 32'h64, 2'b00, 3'h0);
		trn(5'h10, 64'hcf00_0000, 32'h8000_0000, 2'b00, 3'h0);
		trn(5'h11, 64'hc1e0_0000_0010_0000, 32'h8000_0000, 2'b01, 3'h0);
		trn(5'h11, 64'hc1e0_0000_0020_0000, 32'h7fff_ffff, 2'b10, 3'h0);
		trn(5'h10, 64'h4f00_0000, 32'h7fff_ffff, 2'b10, 3'h0);
		trn(5'h10, 64'h7f80_0000, 32'h7fff_ffff, 2'b10, 3'h0);
		trn(5'h11, 64'h7ff8_0000_0000_0000, 32'h7fff_ffff, 2'b10, 3'h0);
		float_control_status_reg_invalid_enable = 1'b1;
		trn(5'h10, 64'hff80_0000, 32'h0, 2'b10, 3'h3);
		float_control_status_reg_inexact_enable = 1'b1;
		trn(5'h10, 64'h4070_0000, 32'h0, 2'b01, 3'h4);
		trn(5'h14, 64'h4070_0000, 32'h0, 2'b00, 3'h5);
		fpu_usable = 1'b0;
		trn(5'h10, 64'h4070_0000, 32'h0, 2'b00, 3'h2);
		fpu_usable = 1'b1;
		// standby is never issued behind a branch here
		issue(sb(19'h0));
		pc_save = in_pc;
		chk({31'h0, standby_stall}, 32'h1);
		issue({6'h00, 5'h1, 5'h2, 5'h11, 5'h0, 6'h26});
		chk({30'h0, gpr_we, standby_stall}, 32'h1);
		wake(4'b0010, 3'h6);
		chk(exc_return_addr, pc_save + 32'h4);
		issue(sb(19'h0));
		wake(4'b0010, 3'h6);
		chk(exc_return_addr, in_pc + 32'h4);
		issue(sb(19'h5a5a5));
		chk({31'h0, standby_stall}, 32'h1);
		wake(4'b0001, 3'h0);
		issue(sb(19'h0));
		wake(4'b0100, 3'h7);
		issue(sb(19'h0));
		wake(4'b1000, 3'h7);
		syscop_usable = 1'b0;
		issue(sb(19'h0));
		exc(3'h2);
		chk({31'h0, standby_stall}, 32'h0);
		summarize();
	end
endmodule
